// *** twc_map.svh ***
`ifndef TWC_MAP_SVH
`define TWC_MAP_SVH

// Register addresses in the special-function space
`define TWC_AUX_ADDR 8'h90
`define TWC_CTL_ADDR 8'h93
`define TWC_STA_ADDR 8'h94
`define TWC_DAT_ADDR 8'h95
`define TWC_ADR_ADDR 8'h96

// Reset values
`define TWC_AUX_RST 8'hFF
`define TWC_CTL_RST 8'h00
`define TWC_DAT_RST 8'hFF
`define TWC_ADR_RST 8'hFE

// Control register fields
`define TWC_B_RHI   7
`define TWC_B_EN    6
`define TWC_B_START 5
`define TWC_B_STOP  4
`define TWC_B_FLAG  3
`define TWC_B_ACK   2
`define TWC_B_RMID  1
`define TWC_B_RLO   0

// Own-address register field
`define TWC_B_GCEN 0

// Auxiliary register fields
`define TWC_B_AUX_DATA 7
`define TWC_B_AUX_CLK  6
`define TWC_B_AUX_KEY  0

// Status codes
`define TWC_ST_ERR      8'h00
`define TWC_ST_START    8'h08
`define TWC_ST_RSTART   8'h10
`define TWC_ST_AW_ACK   8'h18
`define TWC_ST_AW_NAK   8'h20
`define TWC_ST_TD_ACK   8'h28
`define TWC_ST_TD_NAK   8'h30
`define TWC_ST_ARB      8'h38
`define TWC_ST_AR_ACK   8'h40
`define TWC_ST_AR_NAK   8'h48
`define TWC_ST_RD_ACK   8'h50
`define TWC_ST_RD_NAK   8'h58
`define TWC_ST_SW       8'h60
`define TWC_ST_SGC      8'h70
`define TWC_ST_SD_ACK   8'h80
`define TWC_ST_SD_NAK   8'h88
`define TWC_ST_GD_ACK   8'h90
`define TWC_ST_GD_NAK   8'h98
`define TWC_ST_SSTOP    8'hA0
`define TWC_ST_SR       8'hA8
`define TWC_ST_XD_ACK   8'hB8
`define TWC_ST_XD_NAK   8'hC0
`define TWC_ST_XLAST    8'hC8
`define TWC_ST_IDLE     8'hF8

// Quarter-bit dividers, in clk cycles, per rate selection
`define TWC_QDIV_0 8'd64
`define TWC_QDIV_1 8'd56
`define TWC_QDIV_2 8'd48
`define TWC_QDIV_3 8'd40
`define TWC_QDIV_4 8'd240
`define TWC_QDIV_5 8'd30
`define TWC_QDIV_6 8'd15
`define TWC_QDIV_7 8'd8

`endif

// *** twc_pkg.sv ***
package twc_pkg;
  typedef logic [2:0] twc_rate_t;
  // Gray along idle, start, bits, hold
  typedef enum logic [2:0] {
    TWC_IDLE  = 3'b000,
    TWC_START = 3'b001,
    TWC_BITS  = 3'b011,
    TWC_HOLD  = 3'b010,
    TWC_STOP  = 3'b110
  } twc_state_t;
  typedef enum logic [2:0] {
    TWC_NONE, TWC_LISTEN, TWC_MTX, TWC_MRX, TWC_SRX, TWC_STX
  } twc_role_t;
endpackage

// *** twc_sync.sv ***
module twc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import twc_pkg::*;
  logic [W-1:0] m_q;
  // Resets high so idle wires show no false edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m_q <= {W{1'b1}};
      q   <= {W{1'b1}};
    end else begin
      m_q <= d;
      q   <= m_q;
    end
  end
endmodule // twc_sync

// *** twc_rate.sv ***
`include "twc_map.svh"
module twc_rate (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             en,
  input  wire twc_pkg::twc_rate_t sel,
  // Quarter-bit enable pulse
  output logic                  tick
);
  import twc_pkg::*;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] lim;
  logic       tick_d;

  // Divider restarts whenever the block is off
  always_comb begin
    case (sel)
      3'h0: lim = `TWC_QDIV_0;
      3'h1: lim = `TWC_QDIV_1;
      3'h2: lim = `TWC_QDIV_2;
      3'h3: lim = `TWC_QDIV_3;
      3'h4: lim = `TWC_QDIV_4;
      3'h5: lim = `TWC_QDIV_5;
      3'h6: lim = `TWC_QDIV_6;
      default: lim = `TWC_QDIV_7;
    endcase
    tick_d = 1'b0;
    cnt_d  = cnt_q + 8'h01;
    if (!en) begin
      cnt_d = 8'h00;
    end else if (cnt_q >= lim - 8'h01) begin
      cnt_d  = 8'h00;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule // twc_rate

// *** twc_top.sv ***
`include "twc_map.svh"
module twc_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  // Two-wire bus pins
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  // Auxiliary port
  input  wire logic       keyboard_input_line,
  output logic      [4:0] audio_ctl
);
  import twc_pkg::*;

  logic [7:0] ctl_q, ctl_d, dat_q, dat_d, adr_q, adr_d, code_q, code_d, sh_q, sh_d;
  logic [4:0] aux_q, aux_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  twc_state_t st_q, st_d;
  twc_role_t  role_q, role_d;
  logic first_q, first_d, rep_q, rep_d, gc_q, gc_d, last_q, last_d, nak_q, nak_d;
  logic busy_q, busy_d, sda_oe_d, scl_oe_d, sda_p, scl_p, sda_oe_q, scl_oe_q;
  logic sda_s, scl_s, kin_s, tick, si_set, bus_err, gc_hit, own_hit;
  logic scl_rise, scl_fall, start_det, stop_det, master;
  logic [7:0] rdata_d;

  // Pins pass two flops before any logic
  twc_sync #(.W(3)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({sda_i, scl_i, keyboard_input_line}),
    .q    ({sda_s, scl_s, kin_s})
  );

  // Quarter-bit tick for master timing
  twc_rate u_rate (
    .clk  (clk),
    .nrst (nrst),
    .en   (ctl_q[`TWC_B_EN]),
    .sel  ({ctl_q[`TWC_B_RHI], ctl_q[`TWC_B_RMID], ctl_q[`TWC_B_RLO]}),
    .tick (tick)
  );

  // Bus conditions seen on the synchronised wires
  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign master    = (role_q == TWC_MTX) | (role_q == TWC_MRX);
  assign own_hit   = sh_q[7:1] == adr_q[7:1];
  assign gc_hit    = adr_q[`TWC_B_GCEN] & (sh_q == 8'h00);

  // Registers and protocol engine, next values
  always_comb begin
    ctl_d = ctl_q; dat_d = dat_q; adr_d = adr_q; aux_d = aux_q; code_d = code_q;
    st_d = st_q; role_d = role_q; ph_d = ph_q; cnt_d = cnt_q; sh_d = sh_q;
    first_d = first_q; rep_d = rep_q; gc_d = gc_q; last_d = last_q; nak_d = nak_q;
    sda_oe_d = sda_oe_q; scl_oe_d = scl_oe_q;
    si_set = 1'b0;
    bus_err = 1'b0;
    busy_d = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_q);
    // Software writes first so that hardware sets win below
    if (sfr_wr) begin
      case (sfr_addr)
        `TWC_CTL_ADDR: begin
          ctl_d = sfr_wdata;
          ctl_d[`TWC_B_FLAG] = ctl_q[`TWC_B_FLAG] & sfr_wdata[`TWC_B_FLAG];
          if (ctl_q[`TWC_B_FLAG] && !sfr_wdata[`TWC_B_FLAG]) begin
            code_d = `TWC_ST_IDLE;
          end
        end
        `TWC_DAT_ADDR: dat_d = sfr_wdata;
        `TWC_ADR_ADDR: adr_d = sfr_wdata;
        `TWC_AUX_ADDR: aux_d = sfr_wdata[5:1];
        default: ;
      endcase
    end
    if (!ctl_q[`TWC_B_EN]) begin
      // Off: lines released, engine parked
      st_d = TWC_IDLE;
      role_d = TWC_NONE;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end else begin
      case (st_q)
        TWC_IDLE: begin
          sda_oe_d = 1'b0;
          scl_oe_d = 1'b0;
          if (start_det && ctl_q[`TWC_B_ACK] && !ctl_q[`TWC_B_FLAG]) begin
            st_d = TWC_BITS;
            role_d = TWC_LISTEN;
            cnt_d = 4'hF; // The START's own clock fall is skipped
          end else if (ctl_q[`TWC_B_START] && !busy_q && !ctl_q[`TWC_B_FLAG]) begin
            st_d = TWC_START;
            ph_d = 2'd0;
            rep_d = 1'b0;
          end
        end
        TWC_START: if (tick) begin
          case (ph_q)
            2'd0: begin sda_oe_d = 1'b0; ph_d = 2'd1; end
            2'd1: begin scl_oe_d = 1'b0; ph_d = 2'd2; end
            2'd2: if (scl_s && sda_s) begin sda_oe_d = 1'b1; ph_d = 2'd3; end
            default: begin
              scl_oe_d = 1'b1;
              code_d = rep_q ? `TWC_ST_RSTART : `TWC_ST_START;
              si_set = 1'b1;
              st_d = TWC_HOLD;
              role_d = TWC_MTX;
              first_d = 1'b1;
            end
          endcase
        end
        TWC_STOP: if (tick) begin
          case (ph_q)
            2'd0: begin sda_oe_d = 1'b1; scl_oe_d = 1'b1; ph_d = 2'd1; end
            2'd1: begin scl_oe_d = 1'b0; ph_d = 2'd2; end
            2'd2: if (scl_s) ph_d = 2'd3;
            default: begin
              sda_oe_d = 1'b0;
              ctl_d[`TWC_B_STOP] = 1'b0;
              st_d = TWC_IDLE;
              role_d = TWC_NONE;
            end
          endcase
        end
        TWC_HOLD: if (!ctl_q[`TWC_B_FLAG]) begin
          // Software has serviced the flag: resume
          ph_d = 2'd0;
          cnt_d = 4'h0;
          sh_d = dat_q;
          if (master) begin
            if (ctl_q[`TWC_B_STOP]) st_d = TWC_STOP;
            else if (ctl_q[`TWC_B_START]) begin
              st_d = TWC_START;
              rep_d = 1'b1;
            end else st_d = TWC_BITS;
          end else if (role_q == TWC_SRX || role_q == TWC_STX) begin
            st_d = TWC_BITS;
            scl_oe_d = 1'b0;
            if (role_q == TWC_STX) begin
              sda_oe_d = ~dat_q[7];
              last_d = ~ctl_q[`TWC_B_ACK];
            end
          end else begin
            // Internal release only, no STOP on the wire
            st_d = TWC_IDLE;
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
            ctl_d[`TWC_B_STOP] = 1'b0;
          end
        end
        TWC_BITS: begin
          if (start_det || stop_det) begin
            if (role_q == TWC_LISTEN) begin
              if (stop_det) st_d = TWC_IDLE;
              cnt_d = 4'hF;
            end else if (cnt_q == 4'h0 && (role_q == TWC_SRX || role_q == TWC_STX)) begin
              code_d = `TWC_ST_SSTOP;
              si_set = 1'b1;
              st_d = TWC_HOLD;
              role_d = TWC_NONE;
              sda_oe_d = 1'b0;
            end else begin
              bus_err = 1'b1;
              code_d = `TWC_ST_ERR;
              si_set = 1'b1;
              st_d = TWC_HOLD;
              role_d = TWC_NONE;
              sda_oe_d = 1'b0;
              scl_oe_d = 1'b0;
            end
          end else if (master) begin
            if (tick) begin
              case (ph_q)
                2'd0: begin
                  scl_oe_d = 1'b1;
                  ph_d = 2'd1;
                  if (cnt_q == 4'h8) begin
                    // Transmitter ignores ack-enable and frees the line
                    sda_oe_d = (role_q == TWC_MRX) & ctl_q[`TWC_B_ACK];
                  end else begin
                    sda_oe_d = (role_q == TWC_MTX) & ~sh_q[7];
                  end
                end
                2'd1: begin scl_oe_d = 1'b0; ph_d = 2'd2; end
                2'd2: if (scl_s) begin
                  // Waits here while a slave stretches the clock
                  ph_d = 2'd3;
                  if (cnt_q == 4'h8) nak_d = sda_s;
                  else begin
                    sh_d = {sh_q[6:0], sda_s};
                    if (role_q == TWC_MTX && !sda_oe_q && !sda_s) begin
                      code_d = `TWC_ST_ARB;
                      si_set = 1'b1;
                      st_d = TWC_HOLD;
                      role_d = TWC_NONE;
                      scl_oe_d = 1'b0;
                    end
                  end
                end
                default: begin
                  scl_oe_d = 1'b1;
                  ph_d = 2'd0;
                  if (cnt_q == 4'h8) begin
                    // Ack level kept through the hold: no data edge meets the clock fall
                    dat_d = sh_q;
                    si_set = 1'b1;
                    st_d = TWC_HOLD;
                    first_d = 1'b0;
                    if (first_q && sh_q[0]) begin
                      code_d = nak_q ? `TWC_ST_AR_NAK : `TWC_ST_AR_ACK;
                      role_d = TWC_MRX;
                    end else if (first_q) begin
                      code_d = nak_q ? `TWC_ST_AW_NAK : `TWC_ST_AW_ACK;
                    end else if (role_q == TWC_MTX) begin
                      code_d = nak_q ? `TWC_ST_TD_NAK : `TWC_ST_TD_ACK;
                    end else begin
                      code_d = sda_oe_q ? `TWC_ST_RD_ACK : `TWC_ST_RD_NAK;
                    end
                  end else cnt_d = cnt_q + 4'h1;
                end
              endcase
            end
          end else if (scl_rise) begin
            // Slave samples on the remote master's clock
            if (cnt_q == 4'h8) nak_d = sda_s;
            else sh_d = {sh_q[6:0], sda_s};
          end else if (scl_fall) begin
            if (cnt_q == 4'hF) begin
              cnt_d = 4'h0;
            end else if (cnt_q < 4'h7) begin
              cnt_d = cnt_q + 4'h1;
              if (role_q == TWC_STX) sda_oe_d = ~sh_q[7];
            end else if (cnt_q == 4'h7) begin
              cnt_d = 4'h8;
              case (role_q)
                TWC_LISTEN: begin
                  if ((own_hit || gc_hit) && ctl_q[`TWC_B_ACK]) sda_oe_d = 1'b1;
                  else begin
                    st_d = TWC_IDLE;
                    role_d = TWC_NONE;
                  end
                end
                TWC_SRX: sda_oe_d = ctl_q[`TWC_B_ACK];
                default: sda_oe_d = 1'b0;
              endcase
            end else begin
              // Ack slot over: report and stretch the clock
              sda_oe_d = 1'b0;
              scl_oe_d = 1'b1;
              si_set = 1'b1;
              st_d = TWC_HOLD;
              case (role_q)
                TWC_LISTEN: begin
                  dat_d = sh_q;
                  gc_d = gc_hit;
                  if (sh_q[0] && !gc_hit) begin
                    code_d = `TWC_ST_SR;
                    role_d = TWC_STX;
                  end else begin
                    code_d = gc_hit ? `TWC_ST_SGC : `TWC_ST_SW;
                    role_d = TWC_SRX;
                  end
                end
                TWC_SRX: begin
                  dat_d = sh_q;
                  if (sda_oe_q) code_d = gc_q ? `TWC_ST_GD_ACK : `TWC_ST_SD_ACK;
                  else begin
                    code_d = gc_q ? `TWC_ST_GD_NAK : `TWC_ST_SD_NAK;
                    role_d = TWC_NONE;
                  end
                end
                default: begin
                  if (nak_q) code_d = `TWC_ST_XD_NAK;
                  else if (last_q) code_d = `TWC_ST_XLAST;
                  else code_d = `TWC_ST_XD_ACK;
                  if (nak_q || last_q) role_d = TWC_NONE;
                end
              endcase
            end
          end
        end
        default: st_d = TWC_IDLE;
      endcase
    end
    if (si_set) ctl_d[`TWC_B_FLAG] = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_q <= `TWC_CTL_RST; dat_q <= `TWC_DAT_RST; adr_q <= `TWC_ADR_RST;
      aux_q <= 5'h1F; code_q <= `TWC_ST_IDLE; st_q <= TWC_IDLE; role_q <= TWC_NONE;
      ph_q <= 2'd0; cnt_q <= 4'h0; sh_q <= 8'h00; first_q <= 1'b0; rep_q <= 1'b0;
      gc_q <= 1'b0; last_q <= 1'b0; nak_q <= 1'b0; busy_q <= 1'b0;
      sda_oe <= 1'b0; scl_oe <= 1'b0; sda_p <= 1'b1; scl_p <= 1'b1;
    end else begin
      ctl_q <= ctl_d; dat_q <= dat_d; adr_q <= adr_d; aux_q <= aux_d; code_q <= code_d;
      st_q <= st_d; role_q <= role_d; ph_q <= ph_d; cnt_q <= cnt_d; sh_q <= sh_d;
      first_q <= first_d; rep_q <= rep_d; gc_q <= gc_d; last_q <= last_d;
      nak_q <= nak_d; busy_q <= busy_d; sda_oe <= sda_oe_d; scl_oe <= scl_oe_d;
      sda_p <= sda_s; scl_p <= scl_s;
    end
  end

  assign sda_oe_q = sda_oe;
  assign scl_oe_q = scl_oe;

  // Read data; unmapped addresses answer zero
  always_comb begin
    rdata_d = sfr_rdata;
    if (sfr_rd) begin
      case (sfr_addr)
        `TWC_CTL_ADDR: rdata_d = ctl_q;
        `TWC_STA_ADDR: rdata_d = {code_q[7:3], 3'b000};
        `TWC_DAT_ADDR: rdata_d = dat_q;
        `TWC_ADR_ADDR: rdata_d = adr_q;
        `TWC_AUX_ADDR: rdata_d = {sda_s, scl_s, 1'b0, aux_q[3:0], kin_s};
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  // Pins only ever pull low; outputs held in flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
      sda_o     <= 1'b0;
      scl_o     <= 1'b0;
      audio_ctl <= 5'h1F;
    end else begin
      sfr_rdata <= rdata_d;
      sda_o     <= 1'b0;
      scl_o     <= 1'b0;
      audio_ctl <= aux_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_status_read: assert property (sfr_rd && sfr_addr == `TWC_STA_ADDR |=>
    sfr_rdata == $past(code_q) && sfr_rdata[2:0] == 3'h0) else $error("status read wrong");
  a_idle_code: assert property (!ctl_q[`TWC_B_FLAG] |-> code_q == `TWC_ST_IDLE)
    else $error("code not F8 while flag clear");
  a_code_stable: assert property (ctl_q[`TWC_B_FLAG] && $past(ctl_q[`TWC_B_FLAG])
    |-> $stable(code_q)) else $error("code moved while flag set");
  a_flag_set_wins: assert property (si_set |=> ctl_q[`TWC_B_FLAG])
    else $error("flag set lost");
  a_hold_clock: assert property (st_q == TWC_HOLD && ctl_q[`TWC_B_FLAG] &&
    role_q != TWC_NONE |-> scl_oe) else $error("clock not held");
  a_off_release: assert property (!ctl_q[`TWC_B_EN] |=> !sda_oe && !scl_oe)
    else $error("lines driven while off");
  a_mrx_ack: assert property (ctl_q[`TWC_B_EN] && st_q == TWC_BITS && role_q == TWC_MRX
    && ph_q == 2'd0 && cnt_q == 4'h8 && tick && !start_det && !stop_det
    |=> sda_oe == $past(ctl_q[`TWC_B_ACK])) else $error("master ack wrong");
  a_srx_ack: assert property (ctl_q[`TWC_B_EN] && st_q == TWC_BITS && role_q == TWC_SRX
    && cnt_q == 4'h7 && scl_fall && !start_det && !stop_det
    |=> sda_oe == $past(ctl_q[`TWC_B_ACK])) else $error("slave ack wrong");
  a_start_req: assert property (st_q != TWC_START ##1 st_q == TWC_START
    |-> $past(ctl_q[`TWC_B_START])) else $error("start without request");
  a_stop_req: assert property (st_q != TWC_STOP ##1 st_q == TWC_STOP
    |-> $past(ctl_q[`TWC_B_STOP])) else $error("stop without request");
  a_bus_error: assert property (bus_err |=> code_q == `TWC_ST_ERR && ctl_q[`TWC_B_FLAG])
    else $error("bus error not reported");

  c_master_start: cover property (si_set && code_d == `TWC_ST_START);
  c_slave_read: cover property (si_set && code_d == `TWC_ST_SR);
  c_bus_error: cover property (bus_err);
endmodule // twc_top

// *** twc_slave_model.sv ***
module twc_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // Bus wires
  input  wire logic       sda,
  input  wire logic       scl,
  // Test controls
  input  wire logic       nak,
  input  wire logic [7:0] rd_byte,
  // Pulls the data wire low
  output logic            sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  int         bit_n = 0;
  logic [7:0] sh = 8'h00;
  logic       act = 1'b0;
  logic       adr = 1'b0;
  logic       rdm = 1'b0;
  initial sda_pull = 1'b0;
  // Start arms the address phase, stop goes idle
  always @(sda) if (scl) begin
    bit_n = -1; // The START's clock fall brings it to zero
    act = !sda;
    adr = 1'b1;
    rdm = 1'b0;
    sda_pull = 1'b0;
  end
  // Shift on rise; a refused read byte ends the transfer
  always @(posedge scl) if (act) begin
    if (bit_n < 8) sh = {sh[6:0], sda};
    else if (rdm && !adr && sda) act = 1'b0;
  end
  // Change data only while clock is low
  always @(negedge scl) if (act) begin
    bit_n = bit_n + 1;
    if (bit_n == 9) begin
      bit_n = 0;
      adr = 1'b0;
    end
    if (bit_n == 8 && adr) begin
      rdm = sh[0];
      act = sh[7:1] == ADDR;
    end
    // Released wire floats to the pull-up
    if (bit_n == 8) sda_pull = act && (adr || (!rdm && !nak));
    else sda_pull = rdm && !adr && !rd_byte[7 - bit_n];
  end
endmodule // twc_slave_model

// *** twc_top_tb_top.sv ***
`include "twc_map.svh"
module twc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic       sda_o, sda_oe, scl_o, scl_oe, sl_pull, ack;
  logic [4:0] audio_ctl;
  logic       sda_m = 1'b1;
  logic       scl_m = 1'b1;
  logic       nak = 1'b0;
  logic [7:0] v;
  logic [7:0] rx = 8'h00;
  logic       m_ack = 1'b0;
  int         n_errors = 0;
  int         compares = 0;
  int         cyc = 0;
  // Open-drain wires with pull-ups
  wire sda_w = (sda_oe ? sda_o : 1'b1) & !sl_pull & sda_m;
  wire scl_w = (scl_oe ? scl_o : 1'b1) & scl_m;

  twc_top u_twc_top (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .keyboard_input_line(1'b1), .audio_ctl(audio_ctl));
  twc_slave_model u_twc_slave_model (.sda(sda_w), .scl(scl_w), .nak(nak),
    .rd_byte(8'hC5), .sda_pull(sl_pull));

  always #20 clk = ~clk;

  task automatic wrap_up;
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard, far above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  // Read data is registered at the read edge
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    v = sfr_rdata;
    if (a != `TWC_CTL_ADDR) chk(v, exp);
  endtask

  task automatic wait_code(input logic [7:0] code);
    for (int i = 0; i < 400; i++) begin
      rchk(`TWC_CTL_ADDR, 8'h00);
      if (v[`TWC_B_FLAG] === 1'b1) break;
    end
    rchk(`TWC_STA_ADDR, code);
    chk({7'h00, scl_w}, 8'h00); // Clock held during service
  endtask

  task automatic step(input logic [7:0] ctl, input logic [7:0] code);
    wr(`TWC_CTL_ADDR, ctl);
    wait_code(code);
  endtask

  // Remote master on the wire, 320 ns bit period
  task automatic rm_byte(input logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      scl_m = 1'b0;
      #80 sda_m = (i < 8) ? b[7 - i] : !m_ack;
      #80 scl_m = 1'b1;
      wait (scl_w);
      #80 ack = sda_w;
      if (i < 8) rx = {rx[6:0], sda_w};
      #80;
    end
    scl_m = 1'b0;
  endtask

  task automatic rm_stop;
    sda_m = 1'b0;
    #160 scl_m = 1'b1;
    wait (scl_w);
    #160 sda_m = 1'b1;
    #160;
  endtask

  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    // Reset values and refused accesses
    chk({3'h0, audio_ctl}, 8'h1F);
    rchk(`TWC_STA_ADDR, 8'hF8);
    rchk(`TWC_DAT_ADDR, 8'hFF);
    rchk(`TWC_ADR_ADDR, 8'hFE);
    rchk(`TWC_AUX_ADDR, 8'hDF);
    rchk(8'h91, 8'h00);
    wr(`TWC_STA_ADDR, 8'h00);
    rchk(`TWC_STA_ADDR, 8'hF8);
    wr(`TWC_CTL_ADDR, 8'h08);
    rchk(`TWC_CTL_ADDR, 8'h00);
    chk(v, 8'h00);
    wr(`TWC_AUX_ADDR, 8'h2A);
    rchk(`TWC_AUX_ADDR, 8'hCB);
    chk({3'h0, audio_ctl}, 8'h15);
    // Start refused while disabled
    wr(`TWC_CTL_ADDR, 8'h23);
    repeat (300) @(negedge clk);
    rchk(`TWC_STA_ADDR, 8'hF8);
    chk({6'h0, sda_w, scl_w}, 8'h03);
    // Master write, data refused, then stop
    step(8'hE3, 8'h08);
    wr(`TWC_DAT_ADDR, 8'hA0);
    step(8'hC3, 8'h18);
    nak = 1'b1;
    wr(`TWC_DAT_ADDR, 8'h5A);
    step(8'hC3, 8'h30);
    nak = 1'b0;
    wr(`TWC_CTL_ADDR, 8'hD3);
    repeat (300) @(negedge clk);
    rchk(`TWC_CTL_ADDR, 8'h00);
    chk(v, 8'hC3); // Stop bit cleared
    rchk(`TWC_STA_ADDR, 8'hF8);
    chk({6'h0, sda_w, scl_w}, 8'h03);
    // Master read: ack then not-ack
    step(8'hE3, 8'h08);
    wr(`TWC_DAT_ADDR, 8'hA1);
    step(8'hC3, 8'h40);
    step(8'hC7, 8'h50);
    rchk(`TWC_DAT_ADDR, 8'hC5);
    step(8'hC3, 8'h58);
    wr(`TWC_CTL_ADDR, 8'hD3);
    repeat (300) @(negedge clk);
    // Addressed slave receive
    wr(`TWC_ADR_ADDR, 8'h42);
    wr(`TWC_CTL_ADDR, 8'h44);
    #160 sda_m = 1'b0;
    #160;
    rm_byte(8'h42);
    chk({7'h0, ack}, 8'h00);
    wait_code(8'h60);
    wr(`TWC_CTL_ADDR, 8'h40);
    rm_byte(8'h33);
    chk({7'h0, ack}, 8'h01);
    wait_code(8'h88);
    wr(`TWC_CTL_ADDR, 8'h40);
    rm_stop();
    // Addressed slave transmit, last byte acked by the remote master
    wr(`TWC_CTL_ADDR, 8'h44);
    #160 sda_m = 1'b0;
    #160;
    rm_byte(8'h43);
    chk({7'h0, ack}, 8'h00);
    wait_code(8'hA8);
    wr(`TWC_DAT_ADDR, 8'h96);
    wr(`TWC_CTL_ADDR, 8'h40);
    m_ack = 1'b1;
    rm_byte(8'hFF);
    m_ack = 1'b0;
    chk(rx, 8'h96);
    wait_code(8'hC8);
    wr(`TWC_CTL_ADDR, 8'h40);
    rm_stop();
    // Own address ignored with ack-enable clear
    #160 sda_m = 1'b0;
    #160;
    rm_byte(8'h42);
    chk({7'h0, ack}, 8'h01);
    rm_stop();
    rchk(`TWC_STA_ADDR, 8'hF8);
    wrap_up();
  end
endmodule // twc_top_tb_top
